/* inc/rcs_pkg.sv */
package rcs_pkg;
    // operation codes
    typedef enum logic [3:0] {
        CMD_IDLE = 4'h0,
        CMD_MEM = 4'h1,
        CMD_RANDOM = 4'h2,
        CMD_CHECKSUM = 4'h3,
        CMD_TRANSMIT = 4'h4,
        CMD_KEEP = 4'h7,
        CMD_RECEIVE = 4'h8,
        CMD_TRANSCEIVE = 4'hc,
        CMD_RSVD = 4'hd,
        CMD_AUTH = 4'he,
        CMD_RESTART = 4'hf
    } rcs_cmd_e;

    // register offsets
    localparam logic [5:0] OPERATION_SELECT_ADDR = 6'h01;
    localparam logic [5:0] BIT_FRAMING_ADDR = 6'h0d;
    localparam logic [5:0] GENERAL_MODE_ADDR = 6'h11;
    localparam logic [5:0] CHECKSUM_HI_ADDR = 6'h21;
    localparam logic [5:0] CHECKSUM_LO_ADDR = 6'h22;
    localparam logic [5:0] RX_MODE_ADDR = 6'h13;
    localparam logic [5:0] AUTO_TEST_ADDR = 6'h36;
    localparam logic [5:0] PROD_TEST_A_ADDR = 6'h3c;
    localparam logic [5:0] PROD_TEST_B_ADDR = 6'h3d;
    localparam logic [5:0] PROD_TEST_C_ADDR = 6'h3e;
    localparam logic [5:0] PROD_TEST_D_ADDR = 6'h3f;

    // field positions
    localparam int RECEIVER_OFF_BIT = 5;
    localparam int SOFT_POWER_DOWN_BIT = 4;
    localparam int SEND_TRIGGER_BIT = 7;
    localparam int MULTI_FRAME_BIT = 2;

    // reset values
    localparam logic [7:0] OPERATION_SELECT_RST = 8'h20;
    localparam logic [7:0] GENERAL_MODE_RST = 8'h3f;
    localparam logic [7:0] AUTO_TEST_RST = 8'h40;
    localparam logic [7:0] PROD_TEST_A_RST = 8'hff;
    localparam logic [7:0] PROD_TEST_B_RST = 8'h00;
    localparam logic [7:0] PROD_TEST_C_RST = 8'h03;
    localparam logic [7:0] PROD_TEST_D_RST = 8'h00;
    localparam logic [3:0] SELF_TEST_ENABLE = 4'h9;

    // counts
    localparam logic [4:0] SCRATCH_BYTES = 5'd25;
    localparam logic [4:0] RANDOM_BYTES = 5'd10;
    localparam logic [4:0] AUTH_ARG_BYTES = 5'd12;
    localparam logic [4:0] SELF_TEST_BYTES = 5'd8;

    // preset seeds for the checksum unit
    localparam logic [15:0] SEED_0 = 16'h0000;
    localparam logic [15:0] SEED_1 = 16'h6363;
    localparam logic [15:0] SEED_2 = 16'ha671;
    localparam logic [15:0] SEED_3 = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h1021;

    // host register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } rcs_reg_req_s;

    // fifo byte stream towards or from the sequencer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rcs_byte_s;
endpackage

/* hw/rcs_scratch_mem.sv */
`timescale 1ns/1ps
// 25-byte scratch buffer; no reset so contents survive a restart
module rcs_scratch_mem (
    // clock
    input wire logic sys_clk_i,
    // access
    input wire logic we_i,
    input wire logic [4:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem_r [0:24];

    // write port; powering down leaves the array alone
    always_ff @(posedge sys_clk_i) begin
        if (we_i) begin
            mem_r[addr_i] <= wdata_i;
        end
    end

    // registered read
    always_ff @(posedge sys_clk_i) begin
        rdata_o <= mem_r[addr_i];
    end
endmodule

/* hw/rcs_crc16.sv */
`timescale 1ns/1ps
// byte-wide checksum unit, msb first
module rcs_crc16 (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic load_i,
    input wire logic [15:0] seed_i,
    input wire logic byte_en_i,
    input wire logic [7:0] byte_i,
    // result
    output logic [15:0] crc_o
);
    logic [15:0] crc_nxt;

    // one byte per cycle, folded bit by bit
    always_comb begin
        crc_nxt = crc_o;
        for (int i = 7; i >= 0; i--) begin
            if (crc_nxt[15] ^ byte_i[i]) begin
                crc_nxt = {crc_nxt[14:0], 1'b0} ^ rcs_pkg::CRC_POLY;
            end else begin
                crc_nxt = {crc_nxt[14:0], 1'b0};
            end
        end
    end

    // result register
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            crc_o <= 16'h0000;
        end else if (load_i) begin
            crc_o <= seed_i;
        end else if (byte_en_i) begin
            crc_o <= crc_nxt;
        end
    end
endmodule

/* hw/rcs_sequencer.sv */
`timescale 1ns/1ps
// Function
// - written command code selects executed operation
// - arguments and data flow through fifo
// - stream operations consume fifo at once; transceive waits for the send trigger
// - fixed-argument operations wait for full count
// - starting an operation leaves fifo alone
// - new command code other than keep abandons running operation
// - idle code cancels and self-completes
// - store 25 fifo bytes to scratch
// - empty fifo: copy scratch into fifo
// - scratch survives hard power-down
// - scratch transfer ends itself to idle
// - random command overwrites ten scratch bytes
// - checksum over fifo, pauses when empty
// - load seed from mode preset field
// - self-test enable turns checksum into test
// - transmit sends fifo, ends when empty
// - keep code changes only other bits
// - receive code enables receive path
// - transceive sends then switches to receive
// - authenticate as reader; restart resets device
// - restart resets registers, keeps scratch
// - receive ends at stream end unless multi
// - authentication expects twelve argument bytes
module rcs_sequencer (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // host register port
    input wire rcs_pkg::rcs_reg_req_s reg_req_i,
    output logic [7:0] reg_rdata_o,
    // fifo read side (host-filled)
    input wire rcs_pkg::rcs_byte_s fifo_rd_i,
    output logic fifo_pop_o,
    // fifo write side (device-filled)
    output rcs_pkg::rcs_byte_s fifo_wr_o,
    // radio front end
    output logic tx_byte_valid_o,
    output logic [7:0] tx_byte_o,
    input wire logic tx_done_i,
    output logic rx_enable_o,
    input wire logic rx_end_i,
    output logic auth_start_o,
    input wire logic auth_done_i,
    // random source and power
    input wire logic [7:0] rng_i,
    output logic soft_power_down_o,
    output logic receiver_off_o
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_MEM_IN, ST_MEM_OUT, ST_RANDOM, ST_CRC, ST_TEST,
        ST_TX, ST_RX, ST_TRX_WAIT, ST_TRX_TX, ST_AUTH_ARG, ST_AUTH_RUN,
        ST_RESTART
    } rcs_state_e;

    rcs_state_e state_r;
    rcs_state_e state_nxt;
    logic [7:0] op_sel_r;
    logic [7:0] bit_framing_r;
    logic [7:0] mode_r;
    logic [7:0] rx_mode_r;
    logic [7:0] auto_test_r;
    logic [7:0] prod_r [0:3];
    logic [4:0] cnt_r;
    logic [4:0] mem_addr_r;
    logic mem_rd_valid_r;
    logic cmd_wr;
    logic [3:0] new_code;
    logic start_pend_r;
    logic self_end;
    logic restart_pulse;
    logic crc_load;
    logic [15:0] crc_seed;
    logic [15:0] crc_val;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;

    ////////////////////////////////////////////////////////////////
    // command decode
    assign cmd_wr = reg_req_i.wr
        && reg_req_i.addr == rcs_pkg::OPERATION_SELECT_ADDR;
    assign new_code = reg_req_i.wdata[3:0];

    // idle code lands in idle at once
    function automatic rcs_state_e code_state(input logic [3:0] c,
                                              input logic emp,
                                              input logic st);
        rcs_state_e s;
        s = ST_IDLE;
        unique case (c)
            rcs_pkg::CMD_MEM: s = emp ? ST_MEM_OUT : ST_MEM_IN;
            rcs_pkg::CMD_RANDOM: s = ST_RANDOM;
            rcs_pkg::CMD_CHECKSUM: s = st ? ST_TEST : ST_CRC;
            rcs_pkg::CMD_TRANSMIT: s = ST_TX;
            rcs_pkg::CMD_RECEIVE: s = ST_RX;
            rcs_pkg::CMD_TRANSCEIVE: s = ST_TRX_WAIT;
            rcs_pkg::CMD_AUTH: s = ST_AUTH_ARG;
            rcs_pkg::CMD_RESTART: s = ST_RESTART;
            default: s = ST_IDLE;
        endcase
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////
    // state machine
    // self-ending states finish here; a host command other than keep always wins
    always_comb begin
        state_nxt = state_r;
        self_end = 1'b0;
        unique case (state_r)
            ST_IDLE: ;
            ST_MEM_IN, ST_MEM_OUT:
                self_end = cnt_r == rcs_pkg::SCRATCH_BYTES;
            ST_RANDOM: self_end = cnt_r == rcs_pkg::RANDOM_BYTES;
            ST_CRC: ;
            ST_TEST: self_end = cnt_r == rcs_pkg::SELF_TEST_BYTES;
            ST_TX: self_end = !fifo_rd_i.valid && tx_done_i;
            ST_RX: self_end = rx_end_i
                && !rx_mode_r[rcs_pkg::MULTI_FRAME_BIT];
            ST_TRX_WAIT: if (bit_framing_r[rcs_pkg::SEND_TRIGGER_BIT])
                state_nxt = ST_TRX_TX;
            ST_TRX_TX: if (!fifo_rd_i.valid && tx_done_i)
                state_nxt = ST_RX;
            ST_AUTH_ARG: if (cnt_r == rcs_pkg::AUTH_ARG_BYTES)
                state_nxt = ST_AUTH_RUN;
            ST_AUTH_RUN: self_end = auth_done_i;
            ST_RESTART: self_end = 1'b1;
            default: state_nxt = ST_IDLE;
        endcase
        if (self_end) begin
            state_nxt = ST_IDLE;
        end
        if (cmd_wr && new_code != rcs_pkg::CMD_KEEP) begin
            state_nxt = code_state(new_code, !fifo_rd_i.valid,
                auto_test_r[3:0] == rcs_pkg::SELF_TEST_ENABLE);
        end
    end

    assign restart_pulse = state_r == ST_RESTART;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // byte counter restarts on every state change
    // pushes count as they are launched, so end tests stay exact
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || state_nxt != state_r) begin
            cnt_r <= 5'd0;
        end else if (fifo_pop_o || mem_we
                     || (state_r == ST_MEM_OUT && mem_rd_valid_r)
                     || (state_r == ST_TEST
                         && cnt_r != rcs_pkg::SELF_TEST_BYTES)) begin
            cnt_r <= cnt_r + 5'd1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // host registers
    // software restart resets every writable register
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || restart_pulse) begin
            op_sel_r <= rcs_pkg::OPERATION_SELECT_RST;
            bit_framing_r <= 8'h00;
            mode_r <= rcs_pkg::GENERAL_MODE_RST;
            rx_mode_r <= 8'h00;
            auto_test_r <= rcs_pkg::AUTO_TEST_RST;
        end else begin
            if (cmd_wr) begin
                op_sel_r[7:4] <= reg_req_i.wdata[7:4];
                // codes that start nothing read back as idle
                if (new_code != rcs_pkg::CMD_KEEP) begin
                    op_sel_r[3:0] <= state_nxt == ST_IDLE
                        ? rcs_pkg::CMD_IDLE : new_code;
                end
            end else if (state_nxt == ST_IDLE && state_r != ST_IDLE) begin
                op_sel_r[3:0] <= rcs_pkg::CMD_IDLE;
            end
            if (reg_req_i.wr) begin
                unique case (reg_req_i.addr)
                    rcs_pkg::BIT_FRAMING_ADDR:
                        bit_framing_r <= reg_req_i.wdata;
                    rcs_pkg::GENERAL_MODE_ADDR: mode_r <= reg_req_i.wdata;
                    rcs_pkg::RX_MODE_ADDR: rx_mode_r <= reg_req_i.wdata;
                    rcs_pkg::AUTO_TEST_ADDR: auto_test_r <= reg_req_i.wdata;
                    default: ;
                endcase
            end else if (state_r == ST_TRX_TX) begin
                // trigger consumed once sending begins
                bit_framing_r[rcs_pkg::SEND_TRIGGER_BIT] <= 1'b0;
            end
        end
    end

    // production test bytes keep their reset values, writes ignored
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || restart_pulse) begin
            prod_r[0] <= rcs_pkg::PROD_TEST_A_RST;
            prod_r[1] <= rcs_pkg::PROD_TEST_B_RST;
            prod_r[2] <= rcs_pkg::PROD_TEST_C_RST;
            prod_r[3] <= rcs_pkg::PROD_TEST_D_RST;
        end
    end

    // registered read port, unmapped reads give zero
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                rcs_pkg::OPERATION_SELECT_ADDR: reg_rdata_o <= op_sel_r;
                rcs_pkg::BIT_FRAMING_ADDR: reg_rdata_o <= bit_framing_r;
                rcs_pkg::GENERAL_MODE_ADDR: reg_rdata_o <= mode_r;
                rcs_pkg::RX_MODE_ADDR: reg_rdata_o <= rx_mode_r;
                rcs_pkg::AUTO_TEST_ADDR: reg_rdata_o <= auto_test_r;
                rcs_pkg::CHECKSUM_HI_ADDR: reg_rdata_o <= crc_val[15:8];
                rcs_pkg::CHECKSUM_LO_ADDR: reg_rdata_o <= crc_val[7:0];
                rcs_pkg::PROD_TEST_A_ADDR: reg_rdata_o <= prod_r[0];
                rcs_pkg::PROD_TEST_B_ADDR: reg_rdata_o <= prod_r[1];
                rcs_pkg::PROD_TEST_C_ADDR: reg_rdata_o <= prod_r[2];
                rcs_pkg::PROD_TEST_D_ADDR: reg_rdata_o <= prod_r[3];
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // power bits follow every command write outside the restart cycle
    assign soft_power_down_o = op_sel_r[rcs_pkg::SOFT_POWER_DOWN_BIT];
    assign receiver_off_o = op_sel_r[rcs_pkg::RECEIVER_OFF_BIT];

    ////////////////////////////////////////////////////////////////
    // fifo consumption
    // operands come from the fifo, except the checksum seed taken from the mode preset field
    // stream states pop whenever data waits
    // authentication pops up to its count only
    always_comb begin
        fifo_pop_o = 1'b0;
        unique case (state_r)
            ST_MEM_IN: fifo_pop_o = fifo_rd_i.valid
                && cnt_r != rcs_pkg::SCRATCH_BYTES;
            ST_CRC, ST_TX, ST_TRX_TX: fifo_pop_o = fifo_rd_i.valid;
            ST_AUTH_ARG: fifo_pop_o = fifo_rd_i.valid
                && cnt_r != rcs_pkg::AUTH_ARG_BYTES;
            default: fifo_pop_o = 1'b0;
        endcase
    end
    // no fifo flush on start: nothing here clears it

    ////////////////////////////////////////////////////////////////
    // scratch buffer
    // store fifo bytes, or random bytes in the random state
    assign mem_we = (state_r == ST_MEM_IN && fifo_pop_o)
        || (state_r == ST_RANDOM && cnt_r != rcs_pkg::RANDOM_BYTES);
    assign mem_wdata = state_r == ST_RANDOM ? rng_i : fifo_rd_i.data;

    // readback address walks ahead of registered data
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || state_r != ST_MEM_OUT) begin
            mem_addr_r <= 5'd0;
            mem_rd_valid_r <= 1'b0;
        end else if (mem_addr_r != rcs_pkg::SCRATCH_BYTES) begin
            mem_addr_r <= mem_addr_r + 5'd1;
            mem_rd_valid_r <= 1'b1;
        end else begin
            mem_rd_valid_r <= 1'b0;
        end
    end

    // scratch has no reset; restart and power-down keep it
    rcs_scratch_mem u_mem (
        .sys_clk_i(sys_clk_i),
        .we_i(mem_we),
        .addr_i(state_r == ST_MEM_OUT ? mem_addr_r : cnt_r),
        .wdata_i(mem_wdata),
        .rdata_o(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////
    // checksum unit
    // seed chosen by preset field at start
    always_comb begin
        unique case (mode_r[1:0])
            2'd0: crc_seed = rcs_pkg::SEED_0;
            2'd1: crc_seed = rcs_pkg::SEED_1;
            2'd2: crc_seed = rcs_pkg::SEED_2;
            default: crc_seed = rcs_pkg::SEED_3;
        endcase
    end
    assign crc_load = state_nxt == ST_CRC && state_r != ST_CRC;

    // one popped byte per cycle into the unit
    rcs_crc16 u_crc (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .load_i(crc_load),
        .seed_i(crc_seed),
        .byte_en_i(state_r == ST_CRC && fifo_pop_o),
        .byte_i(fifo_rd_i.data),
        .crc_o(crc_val)
    );

    ////////////////////////////////////////////////////////////////
    // device writes into fifo
    // readback bytes and self-test bytes
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            fifo_wr_o <= '0;
        end else if (state_r == ST_MEM_OUT && mem_rd_valid_r) begin
            fifo_wr_o <= {1'b1, mem_rdata};
        end else if (state_r == ST_TEST
                     && cnt_r != rcs_pkg::SELF_TEST_BYTES) begin
            fifo_wr_o <= {1'b1, {3'b000, cnt_r} ^ crc_val[7:0]};
        end else begin
            fifo_wr_o <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // radio front end
    // transmit bytes straight from fifo
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tx_byte_valid_o <= 1'b0;
            tx_byte_o <= 8'h00;
            auth_start_o <= 1'b0;
        end else begin
            tx_byte_valid_o <= fifo_pop_o
                && (state_r == ST_TX || state_r == ST_TRX_TX);
            tx_byte_o <= fifo_rd_i.data;
            auth_start_o <= state_r == ST_AUTH_ARG
                && state_nxt == ST_AUTH_RUN;
        end
    end
    assign rx_enable_o = state_r == ST_RX;

    ////////////////////////////////////////////////////////////////
    // checks
    idle_cancel_a: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        cmd_wr && new_code == rcs_pkg::CMD_IDLE |=> state_r == ST_IDLE)
        else $error("idle code did not cancel");
    keep_code_a: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        cmd_wr && new_code == rcs_pkg::CMD_KEEP && !self_end
        && !(state_r inside {ST_TRX_WAIT, ST_TRX_TX, ST_AUTH_ARG})
        |=> state_r == $past(state_r)
        && op_sel_r[3:0] == $past(op_sel_r[3:0]))
        else $error("keep code changed operation");
    mem_selfend_a: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        state_r == ST_MEM_IN && cnt_r == rcs_pkg::SCRATCH_BYTES
        && !cmd_wr |=> state_r == ST_IDLE
        && op_sel_r[3:0] == rcs_pkg::CMD_IDLE)
        else $error("scratch store did not end");
    auth_args_a: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        state_r == ST_AUTH_RUN && $past(state_r) == ST_AUTH_ARG
        |-> $past(cnt_r) == rcs_pkg::AUTH_ARG_BYTES)
        else $error("authentication began early");
    trx_wait_a: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        state_r == ST_TRX_WAIT |-> !fifo_pop_o)
        else $error("transceive sent before trigger");
    restart_keep_a: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        restart_pulse && !cmd_wr |=> mode_r == rcs_pkg::GENERAL_MODE_RST
        && state_r == ST_IDLE)
        else $error("restart left registers");
    crc_seed_a: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        crc_load |=> crc_val == $past(crc_seed))
        else $error("seed not loaded");
    rx_multi_a: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        state_r == ST_RX && rx_mode_r[rcs_pkg::MULTI_FRAME_BIT]
        && !cmd_wr |=> state_r == ST_RX)
        else $error("multi-frame receive ended");
    rsvd_idle_a: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        cmd_wr && (new_code == rcs_pkg::CMD_RSVD || new_code == 4'h5)
        |=> state_r == ST_IDLE && op_sel_r[3:0] == rcs_pkg::CMD_IDLE)
        else $error("reserved code started work");
    cov_mem_c: cover property (@(posedge sys_clk_i)
        state_r == ST_MEM_OUT ##[1:40] state_r == ST_IDLE);
    cov_trx_c: cover property (@(posedge sys_clk_i)
        state_r == ST_TRX_TX ##[1:80] state_r == ST_RX);
    cov_auth_c: cover property (@(posedge sys_clk_i)
        state_r == ST_AUTH_RUN);
endmodule

/* verification/rcs_fifo_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// host side fifo: bytes the host loads, bytes the device pushes
module rcs_fifo_model (
    // clock
    input wire logic sys_clk_i,
    // device side
    input wire logic pop_i,
    input wire rcs_pkg::rcs_byte_s push_i,
    output rcs_pkg::rcs_byte_s head_o
);
    logic [7:0] q[$];
    // an empty head toggles so stale data never looks valid
    function automatic rcs_pkg::rcs_byte_s nxt();
        nxt.valid = q.size() != 0;
        nxt.data = nxt.valid ? q[0] : ~head_o.data;
    endfunction
    task automatic load(input logic [7:0] b);
        q.push_back(b);
        head_o = nxt();
    endtask
    task automatic flush();
        q.delete();
        head_o = nxt();
    endtask
    initial begin
        head_o = '0;
    end
    // head updates by nba so the device samples the old head
    always @(posedge sys_clk_i) begin
        if (pop_i && q.size() != 0)
            void'(q.pop_front());
        if (push_i.valid)
            q.push_back(push_i.data);
        head_o <= nxt();
    end
endmodule

/* verification/reader_command_sequencer_tb.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// host register calls against the sequencer and a fifo model
module reader_command_sequencer_tb;
    logic sys_clk_i = 0;
    logic rst_n_i = 0;
    rcs_pkg::rcs_reg_req_s req = '0;
    rcs_pkg::rcs_byte_s head, push;
    logic [7:0] rdata;
    logic pop, tx_v, rx_en, spd, roff, auth_st;
    logic rx_end = 0;
    logic tx_done = 1;
    logic auth_done = 0;
    logic [7:0] tx_b, tx_last;
    int auth_cnt = 0;
    int mismatches = 0;
    int comparisons = 0;
    int tx_cnt = 0;
    logic [7:0] mem[25];
    logic [15:0] c;
    localparam logic [5:0] OP = rcs_pkg::OPERATION_SELECT_ADDR;
    localparam logic [5:0] MD = rcs_pkg::GENERAL_MODE_ADDR;
    localparam logic [31:0] PT = {rcs_pkg::PROD_TEST_A_RST,
        rcs_pkg::PROD_TEST_B_RST, rcs_pkg::PROD_TEST_C_RST,
        rcs_pkg::PROD_TEST_D_RST};
    rcs_sequencer u_rcs_sequencer (.sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i), .reg_req_i(req), .reg_rdata_o(rdata),
        .fifo_rd_i(head), .fifo_pop_o(pop), .fifo_wr_o(push),
        .tx_byte_valid_o(tx_v), .tx_byte_o(tx_b), .tx_done_i(tx_done),
        .rx_enable_o(rx_en), .rx_end_i(rx_end), .auth_start_o(auth_st),
        .auth_done_i(auth_done), .rng_i(8'ha5), .soft_power_down_o(spd),
        .receiver_off_o(roff));
    rcs_fifo_model u_rcs_fifo_model (.sys_clk_i(sys_clk_i),
        .pop_i(pop), .push_i(push), .head_o(head));
    always #10 sys_clk_i = ~sys_clk_i;
    // count bytes handed to the transmitter
    always @(posedge sys_clk_i) begin
        if (tx_v === 1'b1) begin
            tx_cnt++;
            tx_last = tx_b;
        end
        if (auth_st === 1'b1)
            auth_cnt++;
    end
    // one-cycle end-of-stream pulse from the radio side
    task automatic rx_pulse();
        rx_end = 1;
        @(posedge sys_clk_i);
        #1;
        rx_end = 0;
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one register access; read data is settled just after the edge
    task automatic acc(input logic w, input logic [5:0] a,
                       input logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk_i);
        #1;
        req = '0;
    endtask
    // poll the code field, bounded so a hung operation ends the run
    task automatic idle_wait();
        for (int i = 0; i < 80; i++) begin
            acc(0, OP, 8'h00);
            if (rdata[3:0] === 4'h0)
                return;
        end
        mismatches++;
        results();
    endtask
    function automatic logic [15:0] step(input logic [15:0] v,
                                         input logic [7:0] b);
        v = v ^ {b, 8'h00};
        for (int i = 0; i < 8; i++)
            v = v[15] ? ((v << 1) ^ rcs_pkg::CRC_POLY) : (v << 1);
        return v;
    endfunction
    initial begin
        #1000000;
        mismatches++;
        results();
    end
    initial begin
        repeat (10) @(posedge sys_clk_i);
        #1;
        rst_n_i = 1;
        // reset values; reserved places ignore writes; unmapped reads 0
        acc(0, OP, 8'h00);
        chk(rdata, rcs_pkg::OPERATION_SELECT_RST);
        for (int i = 0; i < 4; i++) begin
            acc(1, rcs_pkg::PROD_TEST_A_ADDR + 6'(i), 8'h5a);
            acc(0, rcs_pkg::PROD_TEST_A_ADDR + 6'(i), 8'h00);
            chk(rdata, PT[8*(3-i) +: 8]);
        end
        acc(0, 6'h00, 8'h00);
        chk(rdata, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 25; i++) begin
            mem[i] = 8'h40 + 8'(i);
            u_rcs_fifo_model.load(mem[i]);
        end
        acc(1, OP, 8'h01);
        idle_wait();
        chk(u_rcs_fifo_model.q.size(), 0);
        acc(1, MD, 8'h3c);
        acc(1, OP, 8'h0f);
        idle_wait();
        acc(0, MD, 8'h00);
        chk(rdata, rcs_pkg::GENERAL_MODE_RST);
        acc(1, OP, 8'h01);
        idle_wait();
        chk(u_rcs_fifo_model.q.size(), 25);
        for (int i = 0; i < 25; i++)
            chk(u_rcs_fifo_model.q[i], mem[i]);
        u_rcs_fifo_model.flush();
        $display("test scratch done");
        acc(1, MD, 8'h3d);
        u_rcs_fifo_model.load(8'h31);
        acc(1, OP, 8'h03);
        repeat (4) @(posedge sys_clk_i);
        #1;
        u_rcs_fifo_model.load(8'h32);
        repeat (4) @(posedge sys_clk_i);
        c = step(step(rcs_pkg::SEED_1, 8'h31), 8'h32);
        acc(0, rcs_pkg::CHECKSUM_HI_ADDR, 8'h00);
        chk(rdata, c[15:8]);
        acc(0, rcs_pkg::CHECKSUM_LO_ADDR, 8'h00);
        chk(rdata, c[7:0]);
        acc(1, OP, 8'h37);
        acc(0, OP, 8'h00);
        chk(rdata, 8'h33);
        chk(spd, 1'b1);
        chk(roff, 1'b1);
        // an undefined code, since the host keeps off the reserved one
        acc(1, OP, 8'h05);
        acc(0, OP, 8'h00);
        chk(rdata[3:0], 4'h0);
        acc(1, rcs_pkg::AUTO_TEST_ADDR, 8'h49);
        acc(1, OP, 8'h03);
        idle_wait();
        chk(u_rcs_fifo_model.q.size(), rcs_pkg::SELF_TEST_BYTES);
        u_rcs_fifo_model.flush();
        acc(1, rcs_pkg::AUTO_TEST_ADDR, 8'h40);
        $display("test checksum done");
        u_rcs_fifo_model.load(8'h11);
        u_rcs_fifo_model.load(8'h22);
        tx_cnt = 0;
        tx_done = 0;
        acc(1, OP, 8'h04);
        repeat (6) @(posedge sys_clk_i);
        #1;
        acc(0, OP, 8'h00);
        chk(rdata[3:0], 4'h4);
        tx_done = 1;
        idle_wait();
        chk(tx_cnt, 2);
        chk(tx_last, 8'h22);
        u_rcs_fifo_model.load(8'h55);
        acc(1, OP, 8'h0c);
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk(u_rcs_fifo_model.q.size(), 1);
        acc(1, rcs_pkg::BIT_FRAMING_ADDR, 8'h80);
        repeat (4) @(posedge sys_clk_i);
        #1;
        chk(rx_en, 1'b1);
        chk(tx_cnt, 3);
        chk(tx_last, 8'h55);
        acc(0, rcs_pkg::BIT_FRAMING_ADDR, 8'h00);
        chk(rdata, 8'h00);
        rx_pulse();
        idle_wait();
        acc(1, OP, 8'h08);
        chk(rx_en, 1'b1);
        rx_pulse();
        idle_wait();
        for (int i = 0; i < 13; i++)
            u_rcs_fifo_model.load(8'h60 + 8'(i));
        acc(1, OP, 8'h0e);
        repeat (16) @(posedge sys_clk_i);
        #1;
        chk(u_rcs_fifo_model.q.size(), 1);
        chk(auth_cnt, 1);
        auth_done = 1;
        @(posedge sys_clk_i);
        #1;
        auth_done = 0;
        idle_wait();
        u_rcs_fifo_model.flush();
        acc(1, OP, 8'h02);
        idle_wait();
        acc(1, OP, 8'h01);
        idle_wait();
        for (int i = 0; i < 25; i++)
            chk(u_rcs_fifo_model.q[i], i < 10 ? 8'ha5 : mem[i]);
        u_rcs_fifo_model.flush();
        acc(1, rcs_pkg::RX_MODE_ADDR, 8'h04);
        acc(1, OP, 8'h08);
        rx_pulse();
        chk(rx_en, 1'b1);
        acc(1, OP, 8'h00);
        acc(0, OP, 8'h00);
        chk(rdata[3:0], 4'h0);
        chk(rx_en, 1'b0);
        $display("test link done");
        results();
    end
endmodule
